//--- shared/dcb_regs.vh
`ifndef DCB_REGS_VH
`define DCB_REGS_VH
// ==========================================================
// widths and reset values
`define DCB_CNT_W     16
`define DCB_BUS_W     8
`define DCB_CNT_RST   16'h0000
`define DCB_BYTE_RST  8'h00
// read gate select codes (one-hot, active low gates inverted)
`define DCB_SEL_AL    4'h1
`define DCB_SEL_AH    4'h2
`define DCB_SEL_BL    4'h4
`define DCB_SEL_BH    4'h8
`endif

//--- design/dcb_dual_counter.v
`timescale 1ns/1ns
// Contract
// - two independent 16-bit up-counters, own count clocks
// - counter A counts every rising count edge
// - counter B counts only while enable low
// - active-low clear zeroes both counters
// - register clock edge stores both counts
// - first low gate drives stored A[7:0]
// - first high gate drives stored A[15:8]
// - second low gate drives stored B[7:0]
// - second high gate drives stored B[15:8]
// - read bus 8 bits, bit0 is LSB
// - overflow-ready low while A at full count
`include "dcb_regs.vh"

module dcb_dual_counter #(
    parameter CNT_W = `DCB_CNT_W
) (
    input  wire                  ref_clk,
    input  wire                  rst_n,
    input  wire                  counters_clear_n,
    input  wire                  count_clock_first,
    input  wire                  count_clock_second,
    input  wire                  second_count_enable_n,
    input  wire                  store_clock,
    input  wire                  first_low_byte_gate_n,
    input  wire                  first_high_byte_gate_n,
    input  wire                  second_low_byte_gate_n,
    input  wire                  second_high_byte_gate_n,
    output reg  [`DCB_BUS_W-1:0] read_bus_o,
    output reg  [`DCB_BUS_W-1:0] read_bus_oe_n,
    output reg                   first_overflow_ready_n
);

    // ==========================================================
    // edge detection on the sampled pin clocks
    // pins are sampled by ref_clk, so each pin clock must stay
    // at or below half of ref_clk to be seen
    wire                    rise_a;
    wire                    rise_b;
    wire                    rise_r;
    wire [CNT_W-1:0]        cnt_a_q;
    wire [CNT_W-1:0]        cnt_b_q;
    wire [CNT_W-1:0]        cnt_a_d;
    wire [CNT_W-1:0]        cnt_b_d;
    reg  [CNT_W-1:0]        store_a_q;
    reg  [CNT_W-1:0]        store_b_q;
    reg  [2*`DCB_BUS_W-1:0] wide_a;
    reg  [2*`DCB_BUS_W-1:0] wide_b;
    reg  [3:0]              sel;
    reg  [`DCB_BUS_W-1:0]   byte_d;

    dcb_edge_det u_edge_a
    (
        .clk   (ref_clk),
        .rst_n (rst_n),
        .pin   (count_clock_first),
        .rise  (rise_a)
    );

    dcb_edge_det u_edge_b
    (
        .clk   (ref_clk),
        .rst_n (rst_n),
        .pin   (count_clock_second),
        .rise  (rise_b)
    );

    dcb_edge_det u_edge_r
    (
        .clk   (ref_clk),
        .rst_n (rst_n),
        .pin   (store_clock),
        .rise  (rise_r)
    );

    // ==========================================================
    // counters
    dcb_up_counter #(
        .CNT_W   (CNT_W)
    ) u_cnt_a (
        .clk     (ref_clk),
        .rst_n   (rst_n),
        .clear_n (counters_clear_n),
        .step    (rise_a),
        .next    (cnt_a_d),
        .count_q (cnt_a_q)
    );

    dcb_up_counter #(
        .CNT_W   (CNT_W)
    ) u_cnt_b (
        .clk     (ref_clk),
        .rst_n   (rst_n),
        .clear_n (counters_clear_n),
        .step    (rise_b & ~second_count_enable_n),
        .next    (cnt_b_d),
        .count_q (cnt_b_q)
    );

    // ==========================================================
    // storage register and overflow flag
    always @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            store_a_q              <= {CNT_W{1'b0}};
            store_b_q              <= {CNT_W{1'b0}};
            first_overflow_ready_n <= 1'b1;
        end
        else
        begin
            if (rise_r)
            begin
                store_a_q <= cnt_a_q;
                store_b_q <= cnt_b_q;
            end
            // flag follows the next counter value so it is not a cycle late
            first_overflow_ready_n <= ~(&cnt_a_d) | ~counters_clear_n;
        end
    end

    // ==========================================================
    // byte read bus
    always @*
    begin
        sel = {~second_high_byte_gate_n, ~second_low_byte_gate_n,
               ~first_high_byte_gate_n, ~first_low_byte_gate_n};
        // counters narrower than two bytes read back zero-filled
        wide_a = {(2*`DCB_BUS_W){1'b0}};
        wide_b = {(2*`DCB_BUS_W){1'b0}};
        wide_a[CNT_W-1:0] = store_a_q;
        wide_b[CNT_W-1:0] = store_b_q;
        byte_d = `DCB_BYTE_RST;
        case (sel)
            `DCB_SEL_AL: byte_d = wide_a[7:0];
            `DCB_SEL_AH: byte_d = wide_a[15:8];
            `DCB_SEL_BL: byte_d = wide_b[7:0];
            `DCB_SEL_BH: byte_d = wide_b[15:8];
            default:     byte_d = `DCB_BYTE_RST;
        endcase
    end

    always @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            read_bus_o    <= `DCB_BYTE_RST;
            read_bus_oe_n <= {`DCB_BUS_W{1'b1}};
        end
        else
        begin
            read_bus_o <= byte_d;
            // several gates at once is illegal; bus is released then
            if (sel == `DCB_SEL_AL || sel == `DCB_SEL_AH ||
                sel == `DCB_SEL_BL || sel == `DCB_SEL_BH)
                read_bus_oe_n <= {`DCB_BUS_W{1'b0}};
            else
                read_bus_oe_n <= {`DCB_BUS_W{1'b1}};
        end
    end

endmodule // dcb_dual_counter

// ==========================================================
// rising-edge detector for a pin clock sampled by ref_clk
module dcb_edge_det
(
    input  wire clk,
    input  wire rst_n,
    input  wire pin,
    output wire rise
);

    // pin clocks idle low, so the history resets low and no
    // false edge follows reset
    reg pin_q;

    assign rise = pin & ~pin_q;

    always @(posedge clk)
    begin
        if (!rst_n)
            pin_q <= 1'b0;
        else
            pin_q <= pin;
    end

endmodule // dcb_edge_det

// ==========================================================
// one up-counter with asynchronous clear; wraps from all ones
module dcb_up_counter #(
    parameter CNT_W = `DCB_CNT_W
) (
    input  wire             clk,
    input  wire             rst_n,
    input  wire             clear_n,
    input  wire             step,
    output wire [CNT_W-1:0] next,
    output reg  [CNT_W-1:0] count_q
);

    // next value is exported so the overflow flag lines up with
    // the counter instead of trailing it by a cycle
    assign next = step ? count_q + {{(CNT_W-1){1'b0}}, 1'b1} : count_q;

    // clear acts at once, even with every clock stopped; clear wins
    // over a count edge in the same cycle
    always @(posedge clk or negedge clear_n)
    begin
        if (!clear_n)
            count_q <= {CNT_W{1'b0}};
        else if (!rst_n)
            count_q <= {CNT_W{1'b0}};
        else
            count_q <= next;
    end

endmodule // dcb_up_counter

//--- dv/dcb_mon_monitor.sv
`timescale 1ns/1ns
module dcb_mon(input wire ref_clk, rst_n, counters_clear_n, count_clock_first, store_clock,
    first_low_byte_gate_n, first_high_byte_gate_n, second_low_byte_gate_n,
    second_high_byte_gate_n, first_overflow_ready_n, input wire [7:0] read_bus_o, read_bus_oe_n);
    wire [3:0] g = ~{second_high_byte_gate_n, second_low_byte_gate_n,
        first_high_byte_gate_n, first_low_byte_gate_n};
    wire o = first_overflow_ready_n;
    wire c = count_clock_first;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    sequence one_g; $onehot(g) ##1 $stable(g); endsequence
    // the flag moves at the edge that counts, one sample after the pin rise
    sequence a_edge; $past(c) && !$past(c, 2); endsequence
    drive_on_a: assert property (one_g |=> read_bus_oe_n == 8'h00) else $error("no drive");
    bus_idle_a: assert property (g == 4'h0 [*2] |-> read_bus_oe_n == 8'hFF) else $error("idle");
    multi_gate_a: assert property ($countones(g) > 1 |=> read_bus_oe_n == 8'hFF && read_bus_o == 8'h00) else $error("multi");
    clear_ovf_a: assert property (!counters_clear_n |=> o) else $error("clear");
    ovf_fall_a: assert property ($fell(o) |-> a_edge) else $error("fall");
    ovf_rise_a: assert property ($rose(o) |-> a_edge or !$past(counters_clear_n)) else $error("rise");
    store_hold_a: assert property (($onehot(g) && $stable(g) && !store_clock) [*4] |-> $stable(read_bus_o)) else $error("hold");
    reset_out_a: assert property (disable iff (1'b0) !rst_n |=> read_bus_oe_n == 8'hFF && o) else $error("reset");
endmodule // dcb_mon
bind dcb_dual_counter dcb_mon u_mon(.*);

//--- dv/dcb_reader.sv
`timescale 1ns/1ns
module dcb_reader(input wire ref_clk, input wire [7:0] bus, output wire [3:0] gate_n);
    logic [3:0] sel = 4'h0;
    assign gate_n = ~sel;
    // one byte per gate, a released cycle between gates
    task automatic read_all(output logic [31:0] w);
        for (int i = 0; i < 4; i++) begin
            @(negedge ref_clk) sel = 4'h1 << i;
            repeat (2) @(negedge ref_clk);
            w[i*8+:8] = bus;
            sel = 4'h0;
        end
    endtask
endmodule // dcb_reader

//--- dv/tb.sv
`timescale 1ns/1ns
module tb;
    // shortened counter width keeps the wrap within a short run
    localparam W = 10, MX = (1 << W) - 1;
    logic ref_clk = 0, rst_n = 0, clr_n = 1, ca = 0, cb = 0, en_q = 1, sc = 0, chain = 0;
    wire [7:0] bus, oe_n;
    wire [3:0] g;
    wire ovf;
    int fails = 0, n_compared = 0, ea = 0, eb = 0;
    logic [31:0] w;
    initial forever #25 ref_clk = ~ref_clk;
    dcb_dual_counter #(.CNT_W(W)) dut(.ref_clk(ref_clk), .rst_n(rst_n), .counters_clear_n(clr_n),
        .count_clock_first(ca), .count_clock_second(cb), .second_count_enable_n(chain ? ovf : en_q),
        .store_clock(sc), .first_low_byte_gate_n(g[0]), .first_high_byte_gate_n(g[1]),
        .second_low_byte_gate_n(g[2]), .second_high_byte_gate_n(g[3]),
        .read_bus_o(bus), .read_bus_oe_n(oe_n), .first_overflow_ready_n(ovf));
    dcb_reader m(.ref_clk(ref_clk), .bus(bus), .gate_n(g));
    task chk(string s, logic [31:0] e, logic [31:0] v);
        n_compared++;
        if (v !== e) begin $display("ERROR %s exp %h seen %h", s, e, v); fails++; end
    endtask
    task end_sim;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task p(logic a, logic b);
        @(negedge ref_clk) {ca, cb} = {a, b};
        if (b && (chain ? ea == MX : !en_q)) eb = (eb + 1) & MX;
        if (a) ea = (ea + 1) & MX;
        @(negedge ref_clk) {ca, cb} = 2'b00;
        chk("ovf", ea != MX, ovf);
    endtask
    task rd;
        @(negedge ref_clk) sc = 1;
        @(negedge ref_clk) sc = 0;
        m.read_all(w);
        chk("stored", {eb[15:0], ea[15:0]}, w);
    endtask
    task clr;
        @(negedge ref_clk) {clr_n, ca, cb} = 3'b011;
        @(negedge ref_clk) {clr_n, ca, cb} = 3'b100;
        ea = 0;
        eb = 0;
        rd();
    endtask
    initial begin
        void'($urandom(32'ha847_133d));
        repeat (12) @(posedge ref_clk);
        @(negedge ref_clk) rst_n = 1;
        chk("idle oe", 8'hFF, oe_n);
        for (int t = 0; t < 6; t++) begin
            repeat ($urandom_range(60)) begin
                en_q = $urandom;
                p($urandom, $urandom);
            end
            rd();
            if (t == 3) clr();
            $display("test %0d done", t);
        end
        @(negedge ref_clk) m.sel = 4'h5;
        repeat (2) @(negedge ref_clk);
        chk("multi oe", 8'hFF, oe_n);
        chk("multi bus", 8'h00, bus);
        m.sel = 4'h0;
        $display("test multi done");
        clr();
        chain = 1;
        for (int k = 0; k < 1100 && ovf !== 1'b0; k++) p(1, 1);
        chk("chain full", 32'h0, ovf);
        rd();
        p(1, 1);
        rd();
        $display("test chain done");
        end_sim();
    end
endmodule // tb
